// ### rtl/ssso_cfg.svh
`ifndef SSSO_CFG_SVH
`define SSSO_CFG_SVH

// Register indices; byte address is four times the index
`define SSSO_IDX_CFG_A      8'h19
`define SSSO_IDX_CFG_B      8'h1b
`define SSSO_IDX_CTRL       8'h1c
`define SSSO_IDX_STAT       8'h1d

// Field positions
`define SSSO_BIT_SLOT_MARK  15
`define SSSO_BIT_ZERO_SAMP  2
`define SSSO_BIT_ADDR_SAMP  0
`define SSSO_BIT_IDLE_SYNC  8
`define SSSO_LSB_FUNCTION_PULSE_ADJUST     24
`define SSSO_LSB_PROTOCOL   0
`define SSSO_LSB_SENSOR_ID  4
`define SSSO_LSB_TICK_DIV   8

// Reset values
`define SSSO_RST_CFG_A      32'h0000_0000
`define SSSO_RST_CFG_B      32'h0000_0000
`define SSSO_RST_TICK_DIV   8'h4b

// Protocol code and timing counts, in SENT ticks
`define SSSO_MODE_LONG      3'h7
`define SSSO_FP_MIN_BASE    5'h09
`define SSSO_IDLE_TICKS     10'd510
`define SSSO_SM_UNIT_TICKS  8'h04

`endif

// ### rtl/ssso_pkg.sv
package ssso_pkg;

  // Configuration fields gathered from the registers
  typedef struct packed {
    logic       slot_marking_enable;
    logic       zero_slot_sampling;
    logic       addressed_sampling;
    logic       idle_resync;
    logic [1:0] function_pulse_adjust;
    logic [2:0] output_protocol_select;
    logic [1:0] sensor_id;
    logic [7:0] tick_div;
  } ssso_cfg_type;

  // One-cycle events handed to the rest of the transmitter
  typedef struct packed {
    logic sample_hold;
    logic slot_resync;
    logic func_pulse_ok;
  } ssso_evt_type;

  typedef enum logic [1:0] {
    SSSO_MARK_IDLE = 2'b01,
    SSSO_MARK_HIGH = 2'b10
  } ssso_mark_state_type;

endpackage

// ### rtl/ssso_tick_div.sv
`timescale 1ns/1ps
module ssso_tick_div (
  input  wire logic       pclk,    // System clock
  input  wire logic       presetn, // Async reset, active low
  input  wire logic [7:0] div,     // Clock cycles per SENT tick
  output logic            tick     // One-cycle tick enable
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       wrap;
  logic       tick_q;

  // A divider of zero behaves as one so the tick never stops
  assign wrap  = (cnt_q == 8'h00);
  assign cnt_d = wrap ? ((div == 8'h00) ? 8'h00 : div - 8'h01)
                      : cnt_q - 8'h01;
  assign tick  = tick_q;

  // Down counter, tick on reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= wrap;
    end
  end

endmodule // ssso_tick_div

// ### rtl/ssso_top.sv
// Functional notes
// - With slot marking enabled the bus is held high after each addressing pulse that arrives outside a mark, for a time set by sensor ID, otherwise never.
// - With zero-slot sampling enabled a sample-and-hold fires whenever the slot counter returns to zero, otherwise slot zero does nothing.
// - The function pulse adjust field counts only in the long shared-bus Output_protocol_select, protocol code 7.
// - The minimum accepted function output pulse is 9 ticks plus the 2-bit adjust code, so 9 to 12 ticks.
// - With idle resync enabled a line idle for more than 510 ticks resets the slot counter, otherwise idle does nothing.
// - With addressed sampling a sample request fires sample-and-hold only when it addresses this sensor, else every request is broadcast.
`timescale 1ns/1ps
`include "ssso_cfg.svh"
module ssso_top #(
  parameter logic [7:0] SM_UNIT_TICKS = `SSSO_SM_UNIT_TICKS // Mark unit
) (
  input  wire logic                  pclk,          // 25 MHz clock
  input  wire logic                  presetn,       // Async reset, low
  input  wire logic                  psel,          // APB select
  input  wire logic                  penable,       // APB enable
  input  wire logic                  pwrite,        // APB direction
  input  wire logic [11:0]           paddr,         // APB byte address
  input  wire logic [31:0]           pwdata,        // APB write data
  output logic      [31:0]           prdata,        // APB read data
  output logic                       pready,        // APB ready
  output logic                       pslverr,       // APB error
  input  wire logic                  sent_line_in,  // SENT bus level pin
  input  wire logic                  addr_pulse,    // Addressing pulse
  input  wire logic                  sample_req,    // Sample request
  input  wire logic                  sample_match,  // Request is ours
  input  wire logic                  slot_zero_evt, // Slot counter hit 0
  output logic                       bus_high,      // Hold bus high
  output logic      [4:0]            fp_min,        // Min pulse, ticks
  output ssso_pkg::ssso_evt_type     evt            // Event pulses
);

  // Registers
  ssso_pkg::ssso_cfg_type        cfg_q;
  ssso_pkg::ssso_cfg_type        cfg_d;
  ssso_pkg::ssso_mark_state_type mark_q;
  ssso_pkg::ssso_mark_state_type mark_d;
  ssso_pkg::ssso_evt_type        evt_q;
  ssso_pkg::ssso_evt_type        evt_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pslverr_q;
  logic        line_s1_q;
  logic        line_s2_q;
  logic        line_d3_q;
  logic [4:0]  low_cnt_q;
  logic [4:0]  low_cnt_d;
  logic [9:0]  idle_cnt_q;
  logic [9:0]  idle_cnt_d;
  logic [7:0]  mark_cnt_q;
  logic [7:0]  mark_cnt_d;
  logic        bus_high_q;
  logic [4:0]  fp_min_q;

  // Decode and helper wires
  logic        tick;
  logic        setup;
  logic        wr_en;
  logic [7:0]  idx;
  logic        hit_a;
  logic        hit_b;
  logic        hit_c;
  logic        hit_s;
  logic        mapped;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic [31:0] rd_c;
  logic [31:0] rd_s;
  logic        rise;
  logic        fall;
  logic [4:0]  fp_min_d;
  logic        idle_over;
  logic        mark_start;
  logic        mark_end;

  // Minimum function pulse width for a mode and adjust code
  function automatic logic [4:0] min_width(input logic [2:0] mode,
                                           input logic [1:0] adj);
    logic [4:0] add;
    add = (mode == `SSSO_MODE_LONG) ? {3'h0, adj} : 5'h00;
    min_width = `SSSO_FP_MIN_BASE + add;
  endfunction

  // Length of the slot mark: one unit per ID step, ID 0 gives one unit
  function automatic logic [7:0] mark_len(input logic [1:0] id,
                                          input logic [7:0] unit);
    logic [15:0] prod;
    prod = ({6'h00, id} + 8'h01) * unit;
    mark_len = prod[7:0];
  endfunction

  ssso_tick_div u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (cfg_q.tick_div),
    .tick    (tick)
  );

  // APB decode; read data is captured in the setup cycle so that the
  // access phase completes with no wait state
  assign idx    = paddr[9:2];
  assign hit_a  = (idx == `SSSO_IDX_CFG_A) && (paddr[11:10] == 2'h0);
  assign hit_b  = (idx == `SSSO_IDX_CFG_B) && (paddr[11:10] == 2'h0);
  assign hit_c  = (idx == `SSSO_IDX_CTRL)  && (paddr[11:10] == 2'h0);
  assign hit_s  = (idx == `SSSO_IDX_STAT)  && (paddr[11:10] == 2'h0);
  assign mapped = hit_a | hit_b | hit_c | hit_s;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready_q & pwrite & ~pslverr_q;

  // Read images; unused bits read as zero
  assign rd_a = (32'h1 << `SSSO_BIT_SLOT_MARK) &
                  {32{cfg_q.slot_marking_enable}}
              | (32'h1 << `SSSO_BIT_ZERO_SAMP) &
                  {32{cfg_q.zero_slot_sampling}}
              | (32'h1 << `SSSO_BIT_ADDR_SAMP) &
                  {32{cfg_q.addressed_sampling}};
  assign rd_b = ({30'h0, cfg_q.function_pulse_adjust}
                  << `SSSO_LSB_FUNCTION_PULSE_ADJUST)
              | (32'h1 << `SSSO_BIT_IDLE_SYNC) & {32{cfg_q.idle_resync}};
  assign rd_c = ({29'h0, cfg_q.output_protocol_select}
                  << `SSSO_LSB_PROTOCOL)
              | ({30'h0, cfg_q.sensor_id} << `SSSO_LSB_SENSOR_ID)
              | ({24'h0, cfg_q.tick_div} << `SSSO_LSB_TICK_DIV);
  assign rd_s = {6'h00, fp_min_q, mark_cnt_q, 1'b0, idle_cnt_q,
                 line_s2_q, bus_high_q};
  assign prdata_d = hit_a ? rd_a : hit_b ? rd_b :
                    hit_c ? rd_c : hit_s ? rd_s : 32'h0000_0000;

  // Register writes; the status word is read only
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en && hit_a) begin
      cfg_d.slot_marking_enable = pwdata[`SSSO_BIT_SLOT_MARK];
      cfg_d.zero_slot_sampling  = pwdata[`SSSO_BIT_ZERO_SAMP];
      cfg_d.addressed_sampling  = pwdata[`SSSO_BIT_ADDR_SAMP];
    end
    if (wr_en && hit_b) begin
      cfg_d.function_pulse_adjust = pwdata[`SSSO_LSB_FUNCTION_PULSE_ADJUST +: 2];
      cfg_d.idle_resync           = pwdata[`SSSO_BIT_IDLE_SYNC];
    end
    if (wr_en && hit_c) begin
      cfg_d.output_protocol_select = pwdata[`SSSO_LSB_PROTOCOL +: 3];
      cfg_d.sensor_id              = pwdata[`SSSO_LSB_SENSOR_ID +: 2];
      cfg_d.tick_div               = pwdata[`SSSO_LSB_TICK_DIV +: 8];
    end
  end

  // APB handshake and configuration storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q     <= '{tick_div: `SSSO_RST_TICK_DIV, default: '0};
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // Line edges come from the synchronised copy only
  assign rise = line_s2_q & ~line_d3_q;
  assign fall = ~line_s2_q & line_d3_q;

  // Low-pulse width in ticks, saturating so long pulses stay valid
  assign low_cnt_d = fall ? 5'h00 :
                     (tick && !line_s2_q && low_cnt_q != 5'h1f) ?
                     low_cnt_q + 5'h01 : low_cnt_q;
  assign fp_min_d  = min_width(cfg_q.output_protocol_select,
                               cfg_q.function_pulse_adjust);

  // Idle time in ticks; stops at 511 so the resync fires only once
  assign idle_over  = tick && line_s2_q &&
                      (idle_cnt_q == `SSSO_IDLE_TICKS);
  assign idle_cnt_d = !line_s2_q ? 10'd0 :
                      (tick && idle_cnt_q != 10'h3ff &&
                       idle_cnt_q <= `SSSO_IDLE_TICKS) ?
                      idle_cnt_q + 10'd1 : idle_cnt_q;

  // Event pulses towards the slot counter and the angle hold
  assign evt_d.sample_hold = (cfg_q.zero_slot_sampling & slot_zero_evt)
                           | (sample_req & (~cfg_q.addressed_sampling
                                            | sample_match));
  assign evt_d.slot_resync   = idle_over & cfg_q.idle_resync;
  assign evt_d.func_pulse_ok = rise && (low_cnt_q >= fp_min_q);

  // Line sampling and the timing counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_s1_q  <= 1'b1;
      line_s2_q  <= 1'b1;
      line_d3_q  <= 1'b1;
      low_cnt_q  <= 5'h00;
      idle_cnt_q <= 10'd0;
      fp_min_q   <= `SSSO_FP_MIN_BASE;
      evt_q      <= '0;
    end else begin
      line_s1_q  <= sent_line_in;
      line_s2_q  <= line_s1_q;
      line_d3_q  <= line_s2_q;
      low_cnt_q  <= low_cnt_d;
      idle_cnt_q <= idle_cnt_d;
      fp_min_q   <= fp_min_d;
      evt_q      <= evt_d;
    end
  end

  // Slot mark: a new addressing pulse during a mark is ignored so the
  // mark length cannot be stretched by bus noise
  assign mark_start = addr_pulse & cfg_q.slot_marking_enable;
  assign mark_end   = tick && (mark_cnt_q <= 8'h01);

  always_comb begin
    mark_d     = mark_q;
    mark_cnt_d = mark_cnt_q;
    unique case (mark_q)
      ssso_pkg::SSSO_MARK_IDLE: begin
        if (mark_start) begin
          mark_d     = ssso_pkg::SSSO_MARK_HIGH;
          mark_cnt_d = mark_len(cfg_q.sensor_id, SM_UNIT_TICKS);
        end
      end
      ssso_pkg::SSSO_MARK_HIGH: begin
        if (mark_end) begin
          mark_d     = ssso_pkg::SSSO_MARK_IDLE;
          mark_cnt_d = 8'h00;
        end else if (tick) begin
          mark_cnt_d = mark_cnt_q - 8'h01;
        end
      end
      default: begin
        mark_d     = ssso_pkg::SSSO_MARK_IDLE;
        mark_cnt_d = 8'h00;
      end
    endcase
  end

  // Mark state and the registered bus-high request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_q     <= ssso_pkg::SSSO_MARK_IDLE;
      mark_cnt_q <= 8'h00;
      bus_high_q <= 1'b0;
    end else begin
      mark_q     <= mark_d;
      mark_cnt_q <= mark_cnt_d;
      bus_high_q <= (mark_d == ssso_pkg::SSSO_MARK_HIGH);
    end
  end

  // Outputs straight from flip-flops
  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign bus_high = bus_high_q;
  assign fp_min   = fp_min_q;
  assign evt      = evt_q;

endmodule // ssso_top

// ### testbench/ssso_top_monitor.sv
`timescale 1ns/1ps
module ssso_top_monitor #(
  parameter logic [7:0] SM_UNIT_TICKS = 8'h04 // Mark unit
) (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset
  input wire logic        psel,          // Select
  input wire logic        penable,       // Enable
  input wire logic        pready,        // Ready
  input wire logic        pslverr,       // Error
  input wire logic        sent_line_in,  // Line
  input wire logic        addr_pulse,    // Address
  input wire logic        sample_req,    // Request
  input wire logic        slot_zero_evt, // Slot 0
  input wire logic        bus_high,      // Mark
  input wire logic [4:0]  fp_min,        // Minimum
  input wire ssso_pkg::ssso_evt_type evt // Events
);
  logic [15:0] hi_q; // Raw line high, in cycles
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A tick lasts at least one cycle, so cycles bound idle ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_q <= 16'h0000;
    else if (!sent_line_in)
      hi_q <= 16'h0000;
    else if (hi_q != 16'hffff)
      hi_q <= hi_q + 16'h0001;
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_mark_start: assert property (
    $rose(bus_high) |-> $past(addr_pulse))
    else $error("mark without address");
  a_mark_min_len: assert property ($rose(bus_high) |-> bus_high[*4])
    else $error("mark too short");
  a_hold_has_cause: assert property (
    evt.sample_hold |-> $past(sample_req || slot_zero_evt))
    else $error("sample without cause");
  a_fp_min_range: assert property (
    fp_min >= 5'h09 && fp_min <= 5'h0c)
    else $error("fp_min out of range");
  a_resync_idle: assert property (
    evt.slot_resync |-> hi_q >= 16'd511)
    else $error("resync too early");
  c_hold: cover property (evt.sample_hold);
  c_resync: cover property (evt.slot_resync);
  c_func: cover property (evt.func_pulse_ok);
  c_mark: cover property ($rose(bus_high));
endmodule // ssso_top_monitor

bind ssso_top ssso_top_monitor #(.SM_UNIT_TICKS(SM_UNIT_TICKS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sent_line_in(sent_line_in),
  .addr_pulse(addr_pulse), .sample_req(sample_req),
  .slot_zero_evt(slot_zero_evt), .bus_high(bus_high), .fp_min(fp_min),
  .evt(evt)
);

// ### testbench/ssso_ecu_model.sv
`timescale 1ns/1ps
module ssso_ecu_model (
  input  wire logic pclk,       // Clock
  output logic      sent_line,  // Line, pulled up when idle
  output logic      addr_pulse, // Addressing pulse
  output logic      sample_req, // Sample request
  output logic      match,      // Request is for the sensor
  output logic      slot_zero   // Slot counter wrapped
);
  // Idle bus: pull-up holds the line high
  initial begin
    sent_line = 1'b1;
    addr_pulse = 1'b0;
    sample_req = 1'b0;
    match = 1'b0;
    slot_zero = 1'b0;
  end
  // One-cycle strobe: 0 address, 1 request, 2 slot zero
  task automatic strobe(input int kind, input logic m);
    addr_pulse <= (kind == 0);
    sample_req <= (kind == 1);
    slot_zero <= (kind == 2);
    match <= m;
    @(posedge pclk);
    addr_pulse <= 1'b0;
    sample_req <= 1'b0;
    slot_zero <= 1'b0;
    match <= ~m; // Unqualified now, so never a stale value
  endtask
  // Low pulse of a whole number of cycles
  task automatic low(input int cyc);
    sent_line <= 1'b0;
    repeat (cyc) @(posedge pclk);
    sent_line <= 1'b1;
  endtask
endmodule // ssso_ecu_model

// ### testbench/shared_sent_slot_options_tb.sv
`timescale 1ns/1ps
`include "ssso_cfg.svh"
module shared_sent_slot_options_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        sent_line_in, addr_pulse, sample_req, sample_match;
  logic        slot_zero_evt, bus_high;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  fp_min;
  ssso_pkg::ssso_evt_type evt;
  int          mismatches, tests_run, s, d;
  int          cnt [4] = '{default: 0}; // hold, resync, func ok, mark
  int          ca [5] = '{0, 1, 1, 0, 4};
  int          kd [5] = '{1, 1, 1, 2, 2};
  int          mt [5] = '{0, 0, 1, 0, 0};
  int          ex [5] = '{1, 0, 1, 0, 1};
  ssso_top u_ssso_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sent_line_in(sent_line_in), .addr_pulse(addr_pulse),
    .sample_req(sample_req), .sample_match(sample_match),
    .slot_zero_evt(slot_zero_evt), .bus_high(bus_high), .fp_min(fp_min),
    .evt(evt));
  ssso_ecu_model u_ssso_ecu_model (.pclk(pclk), .sent_line(sent_line_in),
    .addr_pulse(addr_pulse), .sample_req(sample_req),
    .match(sample_match), .slot_zero(slot_zero_evt));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Counted mid-cycle so edge updates never race the count
  always @(negedge pclk) begin
    cnt[0] += evt.sample_hold;
    cnt[1] += evt.slot_resync;
    cnt[2] += evt.func_pulse_ok;
    cnt[3] += bus_high;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer, then one idle cycle; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog, well past the ~2500 cycles the tests need
  initial begin
    #400000;
    mismatches++;
    results;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1, `SSSO_IDX_CTRL, 32'h0000_0210); // Tick of 2 cycles, id 1
    apb(0, `SSSO_IDX_CFG_A, 32'h0);
    chk(rd, `SSSO_RST_CFG_A);
    apb(0, `SSSO_IDX_CFG_B, 32'h0);
    chk(rd, `SSSO_RST_CFG_B);
    chk(32'(fp_min), 32'h9);
    apb(0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset and map done");
    apb(1, `SSSO_IDX_CFG_B, 32'h0300_0000);
    // The minimum is registered one cycle after the write lands
    @(posedge pclk);
    chk(32'(fp_min), 32'h9);
    apb(1, `SSSO_IDX_CTRL, 32'h0000_0217);
    for (int a = 0; a < 4; a++) begin
      apb(1, `SSSO_IDX_CFG_B, {6'h00, 2'(a), 24'h0});
      @(posedge pclk);
      chk(32'(fp_min), 32'(9 + a));
    end
    apb(0, `SSSO_IDX_CFG_B, 32'h0);
    chk(rd, 32'h0300_0000);
    // Minimum now 12 ticks, 2 cycles each
    s = cnt[2];
    u_ssso_ecu_model.low(20);
    repeat (12) @(posedge pclk);
    chk(32'(cnt[2] - s), 32'h0);
    u_ssso_ecu_model.low(28);
    repeat (12) @(posedge pclk);
    chk(32'(cnt[2] - s), 32'h1);
    apb(1, `SSSO_IDX_CTRL, 32'h0000_0210);
    u_ssso_ecu_model.low(20);
    repeat (12) @(posedge pclk);
    chk(32'(cnt[2] - s), 32'h2);
    $display("pulse width done");
    for (int i = 0; i < 5; i++) begin
      apb(1, `SSSO_IDX_CFG_A, 32'(ca[i]));
      s = cnt[0];
      u_ssso_ecu_model.strobe(kd[i], mt[i][0]);
      repeat (3) @(posedge pclk);
      chk(32'(cnt[0] - s), 32'(ex[i]));
    end
    $display("sampling done");
    s = cnt[3];
    u_ssso_ecu_model.strobe(0, 1'b0);
    repeat (30) @(posedge pclk);
    chk(32'(cnt[3] - s), 32'h0);
    apb(1, `SSSO_IDX_CFG_A, 32'h0000_8000);
    s = cnt[3];
    u_ssso_ecu_model.strobe(0, 1'b0);
    repeat (4) @(posedge pclk);
    u_ssso_ecu_model.strobe(0, 1'b0);
    repeat (40) @(posedge pclk);
    d = cnt[3] - s;
    chk(32'(d >= 15 && d <= 17), 32'h1); // (8 ticks of 2 cycles)
    $display("slot mark done");
    apb(1, `SSSO_IDX_CFG_B, 32'h0300_0100);
    s = cnt[1];
    u_ssso_ecu_model.low(4);
    repeat (1100) @(posedge pclk);
    chk(32'(cnt[1] - s), 32'h1);
    apb(1, `SSSO_IDX_CFG_B, 32'h0300_0000);
    s = cnt[1];
    u_ssso_ecu_model.low(4);
    repeat (1100) @(posedge pclk);
    chk(32'(cnt[1] - s), 32'h0);
    // Idle count saturated at 511, line high, minimum 9, no mark
    apb(0, `SSSO_IDX_STAT, 32'h0);
    chk(rd, 32'h0120_07fe);
    $display("idle resync done");
    results;
  end
endmodule // shared_sent_slot_options_tb
